/* File: pkg/clk_switch_pkg.sv */
// Constants for the clock-switch sequencer and RC trim register.
// Assumes a 125 MHz system clock and a plain strobe register port.
package clk_switch_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 16;
    localparam logic [3:0]  ADDR_CTRL_LO  = 4'h0;
    localparam logic [3:0]  ADDR_CTRL_HI  = 4'h1;
    localparam logic [3:0]  ADDR_TRIM     = 4'h2;

    // ****************************************
    // Unlock keys
    // ****************************************
    localparam logic [7:0]  KEY_HI_FIRST  = 8'h78;
    localparam logic [7:0]  KEY_HI_SECOND = 8'h9A;
    localparam logic [7:0]  KEY_LO_FIRST  = 8'h46;
    localparam logic [7:0]  KEY_LO_SECOND = 8'h57;

    // ****************************************
    // Control word field positions and trim field width
    // ****************************************
    localparam int          CUR_LSB       = 12;
    localparam int          NEW_LSB       = 8;
    localparam int          LOCK_BIT      = 5;
    localparam int          FAIL_BIT      = 3;
    localparam int          SEC_EN_BIT    = 1;
    localparam int          REQ_BIT       = 0;
    localparam int          TRIM_W        = 6;

    // ****************************************
    // Source codes
    // ****************************************
    localparam logic [2:0]  SRC_FRC       = 3'h0;
    localparam logic [2:0]  SRC_FRC_PLL   = 3'h1;
    localparam logic [2:0]  SRC_PRI       = 3'h2;
    localparam logic [2:0]  SRC_PRI_PLL   = 3'h3;
    localparam logic [2:0]  SRC_SEC       = 3'h4;
    localparam logic [2:0]  SRC_LOW_POWER_RC      = 3'h5;

    // Oscillator enable lanes
    localparam int          OSC_N         = 4;
    localparam int          OSC_PRI       = 0;
    localparam int          OSC_SEC       = 1;
    localparam int          OSC_FRC       = 2;
    localparam int          OSC_LOW_POWER_RC      = 3;

    // Primary submode codes
    localparam logic [1:0]  SUB_EXT_CLOCK = 2'h0;

    // New-clock cycles before the handover
    localparam int          NEW_CLOCK_WAIT = 10;

endpackage : clk_switch_pkg

/* File: src/unlock_detector.sv */
// Two-key unlock detector guarding one byte of the control register.
// Assumes one access strobe per cycle from the register port.
`timescale 1ns/1ps
`default_nettype none

module unlock_detector #(
    parameter logic [7:0] KEY_FIRST  = 8'h00,
    parameter logic [7:0] KEY_SECOND = 8'h00
) (
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic       access_i,
    input  wire logic       write_i,
    input  wire logic [7:0] data_i,
    output logic            open_o
);

    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_SEEN = 2'b01,
        UL_OPEN = 2'b10
    } unlock_state_t;

    unlock_state_t state;
    unlock_state_t next_state;

    always_comb
    begin
        next_state = state;
        case (state)
            UL_IDLE:
            begin
                if (write_i && data_i == KEY_FIRST)
                    next_state = UL_SEEN;
            end
            UL_SEEN:
            begin
                if (write_i && data_i == KEY_SECOND)
                    next_state = UL_OPEN;
                else if (write_i && data_i == KEY_FIRST)
                    next_state = UL_SEEN;
                else if (access_i)
                    next_state = UL_IDLE;
            end
            UL_OPEN:
            begin
                // One access only, then the byte locks again
                if (access_i)
                    next_state = UL_IDLE;
            end
            default:
                next_state = UL_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            state <= UL_IDLE;
        else
            state <= next_state;
    end

    assign open_o = (state == UL_OPEN);

    key_order_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (open_o && !$past(open_o)) |->
            ($past(write_i && data_i == KEY_SECOND)
             && $past(state, 1) == UL_SEEN))
        else $error("unlock opened without the key pair");

endmodule : unlock_detector

`default_nettype wire

/* File: src/clock_switch_and_rc_trim.sv */
// Oscillator control: RC trim register and clock-switch sequencer.
// Assumes oscillators, start-up timer and PLL sit outside; their status
// inputs and the new-clock tick are synchronous to clk_sys_i.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Trim code is six low bits, signed, zero is factory centre.
// - Trim register bits fifteen to six read zero.
// - Trim steps are not linear or monotonic; code is passed as is.
// - Software may switch among six sources, each switch unlock-guarded.
// - Primary submode comes from configuration only, never from a write.
// - Switching and fail monitor only work when the enable config is zero.
// - With switching off, new source is ignored; current shows reset config.
// - With switching off, the switch request ignores writes and reads zero.
// - High byte write accepted only right after keys 78h then 9Ah.
// - Low byte write accepted only right after keys 46h then 57h.
// - Equal current and new source clears the request and abandons.
// - A valid switch start clears the lock and clock-fail bits.
// - Start the new source; wait start-up timer or PLL lock.
// - Count ten new-clock cycles before moving the system clock.
// - On completion clear request and copy new into current source.
// - Old source stops, unless low-power RC in use or secondary enabled.
// - Processor never stalls during the switching sequence.
// - No direct switch between the two PLL modes.
// - Lock bit is one when locked, zero when unlocked or disabled.
// - Lock bit clears on a valid switch and in non-PLL modes.
module clock_switch_and_rc_trim #(
    parameter int SWITCH_WAIT = clk_switch_pkg::NEW_CLOCK_WAIT
) (
    input  wire logic                              clk_sys_i,
    input  wire logic                              nrst_i,
    input  wire logic [clk_switch_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [clk_switch_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                              reg_write_i,
    input  wire logic                              reg_read_i,
    output logic      [clk_switch_pkg::DATA_W-1:0] reg_rdata_o,
    input  wire logic                              switch_enable_config_i,
    input  wire logic [2:0]                        reset_source_config_i,
    input  wire logic [1:0]                        primary_submode_config_i,
    input  wire logic                              low_power_rc_in_use_i,
    input  wire logic                              startup_timer_done_i,
    input  wire logic                              pll_lock_i,
    input  wire logic                              new_clock_tick_i,
    input  wire logic                              clock_fail_event_i,
    output logic      [2:0]                        clock_select_o,
    output logic      [clk_switch_pkg::OSC_N-1:0]  osc_enable_o,
    output logic                                   pll_enable_o,
    output logic      [1:0]                        primary_submode_o,
    output logic      [clk_switch_pkg::TRIM_W-1:0] trim_code_o,
    output logic                                   switch_busy_o
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [2:0] {
        SW_IDLE  = 3'b000,
        SW_CHECK = 3'b001,
        SW_START = 3'b010,
        SW_COUNT = 3'b011,
        SW_SWAP  = 3'b100
    } switch_state_t;

    switch_state_t               state;
    logic [2:0]                  current_source;
    logic [2:0]                  new_source_select;
    logic [2:0]                  target;
    logic                        switch_request;
    logic                        secondary_osc_enable;
    logic                        clock_fail_flag;
    logic                        pll_lock_status;
    logic [clk_switch_pkg::TRIM_W-1:0] trim_code;
    logic [3:0]                  tick_count;
    logic                        switching_on;
    logic                        hi_open;
    logic                        lo_open;
    logic                        any_access;
    logic                        hi_write;
    logic                        lo_write;
    logic                        hi_accept;
    logic                        lo_accept;
    logic                        abandon;
    logic                        source_ready;
    logic [2:0]                  active_source;
    logic [clk_switch_pkg::DATA_W-1:0] control_word;
    logic [clk_switch_pkg::OSC_N-1:0]  next_osc_enable;

    localparam logic [3:0] WAIT_LAST = 4'(SWITCH_WAIT - 1);

    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == clk_switch_pkg::SRC_FRC_PLL)
                || (src == clk_switch_pkg::SRC_PRI_PLL);
    endfunction : uses_pll

    function automatic logic valid_code(input logic [2:0] src);
        valid_code = (src <= clk_switch_pkg::SRC_LOW_POWER_RC);
    endfunction : valid_code

    function automatic int osc_lane(input logic [2:0] src);
        case (src)
            clk_switch_pkg::SRC_PRI,
            clk_switch_pkg::SRC_PRI_PLL: osc_lane = clk_switch_pkg::OSC_PRI;
            clk_switch_pkg::SRC_SEC:     osc_lane = clk_switch_pkg::OSC_SEC;
            clk_switch_pkg::SRC_LOW_POWER_RC:    osc_lane = clk_switch_pkg::OSC_LOW_POWER_RC;
            default:                     osc_lane = clk_switch_pkg::OSC_FRC;
        endcase
    endfunction : osc_lane

    assign switching_on = !switch_enable_config_i;

    // ****************************************
    // Register port and unlock
    // ****************************************
    assign any_access = reg_write_i || reg_read_i;
    assign hi_write   = reg_write_i && reg_addr_i == clk_switch_pkg::ADDR_CTRL_HI;
    assign lo_write   = reg_write_i && reg_addr_i == clk_switch_pkg::ADDR_CTRL_LO;

    unlock_detector #(
        .KEY_FIRST  (clk_switch_pkg::KEY_HI_FIRST),
        .KEY_SECOND (clk_switch_pkg::KEY_HI_SECOND)
    ) hi_unlock (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .access_i  (any_access),
        .write_i   (hi_write),
        .data_i    (reg_wdata_i[7:0]),
        .open_o    (hi_open)
    );

    unlock_detector #(
        .KEY_FIRST  (clk_switch_pkg::KEY_LO_FIRST),
        .KEY_SECOND (clk_switch_pkg::KEY_LO_SECOND)
    ) lo_unlock (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .access_i  (any_access),
        .write_i   (lo_write),
        .data_i    (reg_wdata_i[7:0]),
        .open_o    (lo_open)
    );

    assign hi_accept = hi_write && hi_open;
    assign lo_accept = lo_write && lo_open;

    always_comb
    begin
        control_word = '0;
        control_word[clk_switch_pkg::CUR_LSB +: 3] = current_source;
        control_word[clk_switch_pkg::NEW_LSB +: 3] = new_source_select;
        control_word[clk_switch_pkg::LOCK_BIT]     = pll_lock_status;
        control_word[clk_switch_pkg::FAIL_BIT]     = clock_fail_flag;
        control_word[clk_switch_pkg::SEC_EN_BIT]   = secondary_osc_enable;
        control_word[clk_switch_pkg::REQ_BIT]      = switch_request;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= '0;
        else if (reg_read_i)
        begin
            case (reg_addr_i)
                clk_switch_pkg::ADDR_CTRL_LO,
                clk_switch_pkg::ADDR_CTRL_HI: reg_rdata_o <= control_word;
                clk_switch_pkg::ADDR_TRIM:
                    reg_rdata_o <= {{(clk_switch_pkg::DATA_W
                                     - clk_switch_pkg::TRIM_W){1'b0}}, trim_code};
                default: reg_rdata_o <= '0;
            endcase
        end
        else
            reg_rdata_o <= '0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            trim_code <= '0;
        else if (reg_write_i && reg_addr_i == clk_switch_pkg::ADDR_TRIM)
            trim_code <= reg_wdata_i[clk_switch_pkg::TRIM_W-1:0];
    end

    assign trim_code_o = trim_code;

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            new_source_select <= reset_source_config_i;
        else if (hi_accept)
            new_source_select <= reg_wdata_i[2:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            secondary_osc_enable <= 1'b0;
        else if (lo_accept)
            secondary_osc_enable <= reg_wdata_i[clk_switch_pkg::SEC_EN_BIT];
    end

    // ****************************************
    // Switch sequencer
    // ****************************************
    // PLL pair refused
    assign abandon = (target == current_source) || !valid_code(target)
        || (uses_pll(target) && uses_pll(current_source));

    assign source_ready =
        (!(osc_lane(target) == clk_switch_pkg::OSC_PRI
           && primary_submode_config_i != clk_switch_pkg::SUB_EXT_CLOCK)
         || startup_timer_done_i)
        && (!uses_pll(target) || pll_lock_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            state <= SW_IDLE;
        else
        begin
            case (state)
                SW_IDLE:  if (switch_request) state <= SW_CHECK;
                SW_CHECK: state <= abandon ? SW_IDLE : SW_START;
                SW_START: if (source_ready) state <= SW_COUNT;
                SW_COUNT:
                begin
                    if (new_clock_tick_i && tick_count == WAIT_LAST)
                        state <= SW_SWAP;
                end
                SW_SWAP:  state <= SW_IDLE;
                default:  state <= SW_IDLE;
            endcase
        end
    end

    // Target latched so a late high-byte write cannot redirect a switch
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            target <= reset_source_config_i;
        else if (state == SW_IDLE)
            target <= new_source_select;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || state != SW_COUNT)
            tick_count <= '0;
        else if (new_clock_tick_i)
            tick_count <= tick_count + 4'h1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || !switching_on)
            switch_request <= 1'b0;
        else if (state == SW_CHECK && abandon)
            switch_request <= 1'b0;
        else if (state == SW_SWAP)
            switch_request <= 1'b0;
        else if (lo_accept && reg_wdata_i[clk_switch_pkg::REQ_BIT])
            switch_request <= 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            current_source <= reset_source_config_i;
        else if (state == SW_SWAP)
            current_source <= target;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            primary_submode_o <= primary_submode_config_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            clock_fail_flag <= 1'b0;
        else if (clock_fail_event_i && switching_on)
            clock_fail_flag <= 1'b1;
        else if (state == SW_CHECK && !abandon)
            clock_fail_flag <= 1'b0;
        else if (lo_accept && !reg_wdata_i[clk_switch_pkg::FAIL_BIT])
            clock_fail_flag <= 1'b0;
    end

    // ****************************************
    // Lock status and oscillator power
    // ****************************************
    assign active_source = (state == SW_IDLE) ? current_source : target;

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            pll_lock_status <= 1'b0;
        else if (state == SW_CHECK && !abandon)
            pll_lock_status <= 1'b0;
        else if (!uses_pll(active_source))
            pll_lock_status <= 1'b0;
        else
            pll_lock_status <= pll_lock_i;
    end

    genvar g;
    generate
        for (g = 0; g < clk_switch_pkg::OSC_N; g++)
        begin : g_osc
            always_comb
            begin
                next_osc_enable[g] = (osc_lane(current_source) == g)
                    || (state != SW_IDLE && state != SW_CHECK
                        && osc_lane(target) == g);
                if (g == clk_switch_pkg::OSC_SEC && secondary_osc_enable)
                    next_osc_enable[g] = 1'b1;
                if (g == clk_switch_pkg::OSC_LOW_POWER_RC && low_power_rc_in_use_i)
                    next_osc_enable[g] = 1'b1;
            end

            always_ff @(posedge clk_sys_i)
            begin
                if (!nrst_i)
                    osc_enable_o[g] <= 1'b0;
                else
                    osc_enable_o[g] <= next_osc_enable[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            pll_enable_o <= 1'b0;
        else
            pll_enable_o <= uses_pll(active_source);
    end

    assign clock_select_o = current_source;
    assign switch_busy_o  = (state != SW_IDLE);

    // ****************************************
    // Checks
    // ****************************************
    // redundant abandon
    redundant_drop_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == SW_CHECK && target == current_source)
            |=> (!switch_request && state == SW_IDLE))
        else $error("redundant switch not abandoned");

    start_clears_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == SW_CHECK && !abandon && !clock_fail_event_i)
            |=> (!clock_fail_flag && !pll_lock_status))
        else $error("valid switch did not clear lock and fail bits");

    tick_wait_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == SW_SWAP) |-> ($past(tick_count) == WAIT_LAST
                                && $past(new_clock_tick_i)))
        else $error("handover before ten new-clock cycles");

    handover_copy_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == SW_SWAP) |=> (current_source == $past(target)
                                && !switch_request))
        else $error("handover did not copy source or clear request");

    request_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $past(!switching_on) |-> !switch_request)
        else $error("switch request set while switching disabled");

    trim_upper_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        ($past(reg_read_i) && $past(reg_addr_i) == clk_switch_pkg::ADDR_TRIM)
            |-> (reg_rdata_o[clk_switch_pkg::DATA_W-1:clk_switch_pkg::TRIM_W] == '0
                 && reg_rdata_o[clk_switch_pkg::TRIM_W-1:0] == trim_code))
        else $error("trim readback wrong");

    hi_locked_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (hi_write && !hi_open) |=> $stable(new_source_select))
        else $error("locked high byte write changed new source");

    pll_pair_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == SW_CHECK && uses_pll(target) && uses_pll(current_source))
            |=> (state == SW_IDLE) ##1 (current_source == $past(current_source, 2)))
        else $error("direct switch between PLL modes performed");

    lock_nonpll_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (state == SW_IDLE && !uses_pll(current_source))
            ##1 (state == SW_IDLE) |-> !pll_lock_status)
        else $error("lock bit set in a non-PLL mode");

endmodule : clock_switch_and_rc_trim

`default_nettype wire

/* File: test/osc_model.sv */
// Behavioural oscillator, start-up timer and PLL beside the sequencer.
// Assumes enables come registered from the design on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module osc_model (
    input  wire logic       clk_sys_i,
    input  wire logic [3:0] osc_enable_i,
    input  wire logic       pll_enable_i,
    output logic            startup_timer_done_o,
    output logic            pll_lock_o,
    output logic            new_clock_tick_o
);
    logic [3:0] pri_cnt = 4'h0;
    logic [3:0] pll_cnt = 4'h0;
    logic       phase   = 1'b0;

    always_ff @(posedge clk_sys_i)
    begin
        pri_cnt <= !osc_enable_i[0] ? 4'h0 : (pri_cnt == 4'hF) ? pri_cnt : pri_cnt + 4'h1;
        pll_cnt <= !pll_enable_i ? 4'h0 : (pll_cnt == 4'hF) ? pll_cnt : pll_cnt + 4'h1;
        phase   <= ~phase;
    end
    assign startup_timer_done_o = (pri_cnt >= 4'h8);
    assign pll_lock_o           = (pll_cnt >= 4'h6);
    assign new_clock_tick_o     = phase & (|osc_enable_i);
endmodule : osc_model

`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the clock-switch sequencer and trim register.
// Assumes the oscillator model answers start-up and tick requests.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end

module tb;
    logic        clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, dis = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, got;
    logic [2:0]  sel;
    logic [3:0]  oe;
    logic [5:0]  trim;
    logic        pll_en, busy, st_done, lock, tick;
    logic [2:0]  rsc = 3'h0;
    logic [1:0]  psub;
    logic        lpu = 1'b0, cfe = 1'b0;
    int          mismatches = 0, n_compared = 0;

    initial forever #4 clk = ~clk;

    clock_switch_and_rc_trim u_dut (.clk_sys_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata),
        .switch_enable_config_i(dis), .reset_source_config_i(rsc),
        .primary_submode_config_i(2'h1), .low_power_rc_in_use_i(lpu),
        .startup_timer_done_i(st_done), .pll_lock_i(lock), .new_clock_tick_i(tick),
        .clock_fail_event_i(cfe), .clock_select_o(sel), .osc_enable_o(oe),
        .pll_enable_o(pll_en), .primary_submode_o(psub), .trim_code_o(trim),
        .switch_busy_o(busy));
    osc_model u_osc (.clk_sys_i(clk), .osc_enable_i(oe), .pll_enable_i(pll_en),
        .startup_timer_done_o(st_done), .pll_lock_o(lock), .new_clock_tick_o(tick));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a; wdata <= d; wr_s <= 1'b1; rd_s <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic idle(input int n);
        wr_s <= 1'b0; rd_s <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic rd(input logic [3:0] a);
        addr <= a; rd_s <= 1'b1; wr_s <= 1'b0;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 got = rdata;
        @(posedge clk);
    endtask : rd
    // keys sent strictly back to back
    task automatic unl(input logic [3:0] a, input logic [7:0] k1, k2, v);
        wr(a, {8'h00, k1}); wr(a, {8'h00, k2}); wr(a, {8'h00, v}); idle(1);
    endtask : unl
    task automatic request(input logic [2:0] s);
        unl(clk_switch_pkg::ADDR_CTRL_HI, clk_switch_pkg::KEY_HI_FIRST,
            clk_switch_pkg::KEY_HI_SECOND, {5'h00, s});
        unl(clk_switch_pkg::ADDR_CTRL_LO, clk_switch_pkg::KEY_LO_FIRST,
            clk_switch_pkg::KEY_LO_SECOND, 8'h01);
    endtask : request
    task automatic do_reset(input logic d, input logic [2:0] r);
        dis <= d; rsc <= r; nrst <= 1'b0; idle(6); nrst <= 1'b1; @(posedge clk);
    endtask : do_reset
    // One-cycle failure report from the fail monitor
    task automatic fail_pulse;
        cfe <= 1'b1; @(posedge clk); cfe <= 1'b0;
    endtask : fail_pulse

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_switch(input logic [2:0] s, input int lane, input logic lk);
        int i;
        request(s);
        @(posedge clk);
        #1 `CHK("busy", 1'b1, busy)
        // bounded wait, then request bit read
        for (i = 0; i < 300 && sel !== s; i++) @(posedge clk);
        // Stuck switch counts as a mismatch and ends the run
        if (i == 300)
        begin
            mismatches++;
            final_report;
        end
        idle(3);
        rd(clk_switch_pkg::ADDR_CTRL_LO);
        `CHK("select", s, sel)
        `CHK("ctrl", {1'b0, s, 1'b0, s, 2'b00, lk, 5'h00}, got)
        `CHK("osc_en", 4'h1 << lane, oe)
        `CHK("pll_en", lk, pll_en)
        `CHK("busy_end", 1'b0, busy)
        $display("test switch to %h done", s);
    endtask : t_switch

    task automatic t_misc;
        rd(clk_switch_pkg::ADDR_CTRL_HI);
        `CHK("rst_ctrl", 16'h0000, got)
        `CHK("submode", 2'h1, psub)
        fail_pulse;
        rd(clk_switch_pkg::ADDR_CTRL_LO);
        `CHK("fail_set", 16'h0008, got)
        wr(clk_switch_pkg::ADDR_TRIM, 16'hFFE0); idle(1);
        rd(clk_switch_pkg::ADDR_TRIM);
        `CHK("trim_rd", 16'h0020, got)
        `CHK("trim_o", 6'h20, trim)
        t_switch(clk_switch_pkg::SRC_SEC, clk_switch_pkg::OSC_SEC, 1'b0);
        t_switch(clk_switch_pkg::SRC_PRI, clk_switch_pkg::OSC_PRI, 1'b0);
        request(clk_switch_pkg::SRC_PRI); idle(6);
        rd(clk_switch_pkg::ADDR_CTRL_LO);
        `CHK("redundant", 16'h2200, got)
        wr(4'h1, 16'h0078); wr(4'h0, 16'h0000); wr(4'h1, 16'h009A); wr(4'h1, 16'h0004);
        idle(1);
        rd(clk_switch_pkg::ADDR_CTRL_HI);
        `CHK("cancel", 16'h2200, got)
        t_switch(clk_switch_pkg::SRC_FRC_PLL, clk_switch_pkg::OSC_FRC, 1'b1);
        // Direct hop between the two PLL modes must be dropped
        request(clk_switch_pkg::SRC_PRI_PLL); idle(6);
        rd(clk_switch_pkg::ADDR_CTRL_LO);
        `CHK("pll_pair", 16'h1320, got)
        $display("test misc done");
    endtask : t_misc

    task automatic t_disabled;
        lpu <= 1'b1;
        do_reset(1'b1, clk_switch_pkg::SRC_PRI);
        request(clk_switch_pkg::SRC_SEC); fail_pulse; idle(30);
        rd(clk_switch_pkg::ADDR_CTRL_LO);
        `CHK("req_off", 1'b0, got[0])
        `CHK("fail_off", 1'b0, got[3])
        `CHK("sel_off", clk_switch_pkg::SRC_PRI, sel)
        `CHK("low_power_rc_keep", 4'h9, oe)
        $display("test disabled done");
    endtask : t_disabled

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        @(posedge clk);
        do_reset(1'b0, clk_switch_pkg::SRC_FRC);
        t_misc;
        t_disabled;
        final_report;
    end
endmodule : tb

`default_nettype wire
